// ---- src/monitor_trigger_defines.svh ----
`ifndef MONITOR_TRIGGER_DEFINES_SVH
`define MONITOR_TRIGGER_DEFINES_SVH
// Notes on behaviour
// - Rising edge on input one starts event monitoring.
// - Falling edge on input two stops event monitoring.
// - Once started, monitoring stays on until a valid stop edge.
// - Rising edge on input three or four logs an all-channel snapshot event.
// - Start/stop and snapshot run side by side, neither blocks the other.
// - A threshold trigger saves waveforms per that parameter's capture bits.
// - Every threshold parameter has its own capture and record-all bits.
// - Capture and record-all both set: save waveforms of all channels.
// - Capture set, record-all clear: save only the triggering channel.
// - Both bits clear: a trigger saves no waveform.
// - Record-all without capture is refused, old value kept, warning sounds.
// - All capture bits are off after reset.
// - Harmonic number 2 to 50 at 60 Hz, 2 to 8 at 400 Hz, else refused.
// - Setup name holds at most 29 characters, further ones refused.
// - Leaving the threshold edit commits all pending settings.
// - Inputs one and two do start/stop only when that pair is enabled.
// - Inputs three and four each have their own snapshot enable.

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_INT_STS    8'h08
`define OFS_INT_MASK   8'h0C
`define OFS_CAPT_EDIT  8'h10
`define OFS_WAVE_EN    8'h14
`define OFS_ALL_EN     8'h18
`define OFS_HARM       8'h1C
`define OFS_EDIT_EXIT  8'h20
`define OFS_NAME_CHAR  8'h24
`define OFS_NAME_LEN   8'h28
`define OFS_NAME_BASE  8'h80

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_PAIR      0
`define CTRL_SNAP3     1
`define CTRL_SNAP4     2
`define CTRL_400HZ     3
`define CTRL_RST       4'h0
`define INT_START      0
`define INT_STOP       1
`define INT_SNAP       2
`define INT_WAVE       3
`define INT_REJECT     4
`define STS_ACTIVE     0
`define STS_DIRTY      1
`define CAPT_WAVE      8
`define CAPT_ALL       9
`define HARM_V_LSB     0
`define HARM_I_LSB     8
`define HARM_RST       6'h03

// ----------------------------------------------------------------------
// Limits
// ----------------------------------------------------------------------
`define PARAM_COUNT    22
`define NAME_MAX       29
`define HARM_MIN       6'h02
`define HARM_MAX_60    6'h32
`define HARM_MAX_400   6'h08
`endif

// ---- src/trig_types_pkg.sv ----
package trig_types_pkg;
   typedef logic [3:0]  chan_mask_t;
   typedef logic [4:0]  param_idx_t;
   typedef logic [5:0]  harm_t;
   typedef logic [7:0]  char_t;
   typedef logic [21:0] param_bits_t;
   typedef logic [4:0]  int_bits_t;
   typedef enum logic {MON_IDLE, MON_ACTIVE} mon_state_t;
endpackage : trig_types_pkg

// ---- src/edge_if.sv ----
interface edge_if;
   logic [3:0] rise;
   logic [3:0] fall;
   modport src (output rise, output fall);
   modport dst (input rise, input fall);
endinterface : edge_if

// ---- src/input_edge_sync.sv ----
module input_edge_sync (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [3:0] pins,
   edge_if.src             ev
);
   import trig_types_pkg::*;

   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic [3:0] s3_r;
   logic [3:0] level_r;
   logic [3:0] rise_r;
   logic [3:0] fall_r;

   // A change is taken only once stages two and three agree, so a level caught
   // mid-transition cannot give a second pulse.
   for (genvar i = 0; i < 4; i++) begin : g_pin
      always_ff @(posedge core_clk) begin
         if (rst) begin
            s1_r[i]    <= 1'b0;
            s2_r[i]    <= 1'b0;
            s3_r[i]    <= 1'b0;
            level_r[i] <= 1'b0;
            rise_r[i]  <= 1'b0;
            fall_r[i]  <= 1'b0;
         end else begin
            s1_r[i]    <= pins[i];
            s2_r[i]    <= s1_r[i];
            s3_r[i]    <= s2_r[i];
            if (s2_r[i] == s3_r[i]) begin
               level_r[i] <= s3_r[i];
            end
            rise_r[i]  <= (s2_r[i] == s3_r[i]) && s3_r[i] && !level_r[i];
            fall_r[i]  <= (s2_r[i] == s3_r[i]) && !s3_r[i] && level_r[i];
         end
      end
   end

   assign ev.rise = rise_r;
   assign ev.fall = fall_r;
endmodule : input_edge_sync

// ---- src/name_store.sv ----
module name_store (
   input  wire logic                  core_clk,
   input  wire logic                  we,
   input  wire logic [4:0]            waddr,
   input  wire trig_types_pkg::char_t wdata,
   input  wire logic [4:0]            raddr,
   output trig_types_pkg::char_t      rdata
);
   import trig_types_pkg::*;

   char_t mem [0:31];
   char_t rdata_r;

   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      rdata_r <= mem[raddr];
   end

   assign rdata = rdata_r;
endmodule : name_store

// ---- src/monitor_trigger_capture_control.sv ----
// The address map and the strobed register port were chosen for this implementation.
`include "monitor_trigger_defines.svh"

module monitor_trigger_capture_control (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire logic [3:0]                 dig_in,
   input  wire logic [7:0]                 reg_addr,
   input  wire logic [31:0]                reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic [31:0]                     reg_rdata,
   input  wire logic                       trig_valid,
   input  wire trig_types_pkg::param_idx_t trig_param,
   input  wire logic [1:0]                 trig_chan,
   output logic                            monitor_active,
   output logic                            digital_snapshot_event,
   output logic                            wave_save,
   output trig_types_pkg::param_idx_t      wave_save_param,
   output trig_types_pkg::chan_mask_t      wave_save_chans,
   output trig_types_pkg::harm_t           voltage_harmonic_limit,
   output trig_types_pkg::harm_t           current_harmonic_limit,
   output logic                            audible_warn,
   output logic                            irq
);
   import trig_types_pkg::*;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic harm_ok(input harm_t n, input logic is_400);
      harm_ok = (n >= `HARM_MIN) && (n <= (is_400 ? `HARM_MAX_400 : `HARM_MAX_60));
   endfunction : harm_ok

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   edge_if ev ();

   logic [3:0]   ctrl_r;
   mon_state_t   mon_r;
   mon_state_t   mon_nxt;
   param_bits_t  wave_en_r;
   param_bits_t  all_en_r;
   param_bits_t  wave_pend_r;
   param_bits_t  all_pend_r;
   harm_t        vharm_r;
   harm_t        iharm_r;
   harm_t        vharm_pend_r;
   harm_t        iharm_pend_r;
   logic         dirty_r;
   int_bits_t    int_sts_r;
   int_bits_t    int_mask_r;
   int_bits_t    int_set;
   logic [4:0]   name_len_r;
   logic         snap_r;
   logic         wave_r;
   param_idx_t   wave_param_r;
   chan_mask_t   wave_chans_r;
   logic         warn_r;
   logic [31:0]  rdata_r;
   logic         name_rd_r;
   char_t        name_q;

   logic         start_ev;
   logic         stop_ev;
   logic         snap_ev;
   logic         trig_hit;
   logic         capt_wr;
   param_idx_t   capt_idx;
   logic         capt_wave;
   logic         capt_all;
   logic         capt_bad;
   logic         harm_wr;
   harm_t        vharm_in;
   harm_t        iharm_in;
   logic         harm_bad;
   logic         exit_wr;
   logic         char_wr;
   logic         char_bad;
   logic         name_sel;
   logic [7:0]   name_ofs;

   input_edge_sync u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .pins     (dig_in),
      .ev       (ev)
   );

   // ----------------------------------------------------------------------
   // Input event decode
   // ----------------------------------------------------------------------
   assign start_ev = ctrl_r[`CTRL_PAIR] && ev.rise[0];
   assign stop_ev  = ctrl_r[`CTRL_PAIR] && ev.fall[1];
   assign snap_ev  = (ctrl_r[`CTRL_SNAP3] && ev.rise[2]) ||
                     (ctrl_r[`CTRL_SNAP4] && ev.rise[3]);

   // ----------------------------------------------------------------------
   // Register write decode
   // ----------------------------------------------------------------------
   assign capt_wr   = reg_wr && hit(reg_addr, `OFS_CAPT_EDIT);
   assign capt_idx  = reg_wdata[4:0];
   assign capt_wave = reg_wdata[`CAPT_WAVE];
   assign capt_all  = reg_wdata[`CAPT_ALL];
   assign capt_bad  = capt_wr && ((capt_idx >= 5'(`PARAM_COUNT)) || (capt_all && !capt_wave));
   assign harm_wr   = reg_wr && hit(reg_addr, `OFS_HARM);
   assign vharm_in  = reg_wdata[`HARM_V_LSB +: 6];
   assign iharm_in  = reg_wdata[`HARM_I_LSB +: 6];
   assign harm_bad  = harm_wr && !(harm_ok(vharm_in, ctrl_r[`CTRL_400HZ]) &&
                                   harm_ok(iharm_in, ctrl_r[`CTRL_400HZ]));
   assign exit_wr   = reg_wr && hit(reg_addr, `OFS_EDIT_EXIT);
   assign char_wr   = reg_wr && hit(reg_addr, `OFS_NAME_CHAR);
   assign char_bad  = char_wr && (name_len_r == 5'(`NAME_MAX));
   assign trig_hit  = trig_valid && (trig_param < 5'(`PARAM_COUNT)) && wave_en_r[trig_param];

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_r <= `CTRL_RST;
      end else if (reg_wr && hit(reg_addr, `OFS_CTRL)) begin
         ctrl_r <= reg_wdata[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // Monitoring state
   // ----------------------------------------------------------------------
   always_comb begin
      mon_nxt = mon_r;
      case (mon_r)
         MON_IDLE: begin
            if (start_ev) begin
               mon_nxt = MON_ACTIVE;
            end
         end
         MON_ACTIVE: begin
            if (stop_ev) begin
               mon_nxt = MON_IDLE;
            end else begin
               mon_nxt = MON_ACTIVE;
            end
         end
         default: begin
            mon_nxt = MON_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mon_r <= MON_IDLE;
      end else begin
         mon_r <= mon_nxt;
      end
   end

   // Snapshot has its own path so it fires in any monitoring state.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         snap_r <= 1'b0;
      end else begin
         snap_r <= snap_ev;
      end
   end

   // ----------------------------------------------------------------------
   // Capture settings, pending and committed
   // ----------------------------------------------------------------------
   // Clearing capture also clears record-all, so the invalid pair is never held.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wave_pend_r <= '0;
         all_pend_r  <= '0;
      end else if (capt_wr && !capt_bad) begin
         wave_pend_r[capt_idx] <= capt_wave;
         all_pend_r[capt_idx]  <= capt_all && capt_wave;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wave_en_r <= '0;
         all_en_r  <= '0;
         vharm_r   <= `HARM_RST;
         iharm_r   <= `HARM_RST;
      end else if (exit_wr) begin
         wave_en_r <= wave_pend_r;
         all_en_r  <= all_pend_r;
         vharm_r   <= vharm_pend_r;
         iharm_r   <= iharm_pend_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         vharm_pend_r <= `HARM_RST;
         iharm_pend_r <= `HARM_RST;
      end else if (harm_wr && !harm_bad) begin
         vharm_pend_r <= vharm_in;
         iharm_pend_r <= iharm_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dirty_r <= 1'b0;
      end else if (exit_wr) begin
         dirty_r <= 1'b0;
      end else if ((capt_wr && !capt_bad) || (harm_wr && !harm_bad)) begin
         dirty_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Waveform save on threshold trigger
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wave_r       <= 1'b0;
         wave_param_r <= '0;
         wave_chans_r <= '0;
      end else begin
         wave_r <= trig_hit;
         if (trig_hit) begin
            wave_param_r <= trig_param;
            if (all_en_r[trig_param]) begin
               wave_chans_r <= 4'hF;
            end else begin
               wave_chans_r <= chan_mask_t'(4'h1 << trig_chan);
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Setup name
   // ----------------------------------------------------------------------
   // A write to the length register starts a fresh name.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         name_len_r <= '0;
      end else if (reg_wr && hit(reg_addr, `OFS_NAME_LEN)) begin
         name_len_r <= '0;
      end else if (char_wr && !char_bad) begin
         name_len_r <= name_len_r + 5'h01;
      end
   end

   assign name_ofs = reg_addr - `OFS_NAME_BASE;
   assign name_sel = (reg_addr >= `OFS_NAME_BASE) && (name_ofs[7:2] < 6'(`NAME_MAX)) &&
                     (name_ofs[1:0] == 2'h0);

   name_store u_name (
      .core_clk (core_clk),
      .we       (char_wr && !char_bad),
      .waddr    (name_len_r),
      .wdata    (reg_wdata[7:0]),
      .raddr    (name_ofs[6:2]),
      .rdata    (name_q)
   );

   // ----------------------------------------------------------------------
   // Warning, interrupts
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         warn_r <= 1'b0;
      end else begin
         warn_r <= capt_bad || harm_bad || char_bad;
      end
   end

   always_comb begin
      int_set              = '0;
      int_set[`INT_START]  = start_ev && (mon_r == MON_IDLE);
      int_set[`INT_STOP]   = stop_ev && (mon_r == MON_ACTIVE);
      int_set[`INT_SNAP]   = snap_ev;
      int_set[`INT_WAVE]   = trig_hit;
      int_set[`INT_REJECT] = capt_bad || harm_bad || char_bad;
   end

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         int_sts_r <= '0;
      end else if (reg_wr && hit(reg_addr, `OFS_INT_STS)) begin
         int_sts_r <= (int_sts_r & ~reg_wdata[4:0]) | int_set;
      end else begin
         int_sts_r <= int_sts_r | int_set;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         int_mask_r <= '0;
      end else if (reg_wr && hit(reg_addr, `OFS_INT_MASK)) begin
         int_mask_r <= reg_wdata[4:0];
      end
   end

   // ----------------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_r   <= '0;
         name_rd_r <= 1'b0;
      end else begin
         rdata_r   <= '0;
         name_rd_r <= reg_rd && name_sel;
         if (reg_rd) begin
            case (reg_addr)
               `OFS_CTRL:     rdata_r <= {28'h000_0000, ctrl_r};
               `OFS_STATUS:   rdata_r <= {30'h0000_0000, dirty_r, mon_r == MON_ACTIVE};
               `OFS_INT_STS:  rdata_r <= {27'h000_0000, int_sts_r};
               `OFS_INT_MASK: rdata_r <= {27'h000_0000, int_mask_r};
               `OFS_WAVE_EN:  rdata_r <= {10'h000, wave_en_r};
               `OFS_ALL_EN:   rdata_r <= {10'h000, all_en_r};
               `OFS_HARM:     rdata_r <= {18'h0_0000, iharm_r, 2'h0, vharm_r};
               `OFS_NAME_LEN: rdata_r <= {27'h000_0000, name_len_r};
               default:       rdata_r <= '0;
            endcase
         end
      end
   end

   assign reg_rdata              = name_rd_r ? {24'h00_0000, name_q} : rdata_r;
   assign monitor_active         = (mon_r == MON_ACTIVE);
   assign digital_snapshot_event = snap_r;
   assign wave_save              = wave_r;
   assign wave_save_param        = wave_param_r;
   assign wave_save_chans        = wave_chans_r;
   assign voltage_harmonic_limit = vharm_r;
   assign current_harmonic_limit = iharm_r;
   assign audible_warn           = warn_r;
   assign irq                    = |(int_sts_r & int_mask_r);
endmodule : monitor_trigger_capture_control

// ---- sim/field_contacts.sv ----
// ----------------------------------------------------------------------
// Field contacts driving the four digital inputs
// ----------------------------------------------------------------------
module field_contacts (
   input  wire logic       core_clk,
   input  wire logic [3:0] req_lvl,
   input  wire logic       req_go,
   input  wire logic       req_slow,
   output logic [3:0]      dig_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_r;
   logic [3:0] lvl_r;
   logic       pend_r;

   // A slow contact closes three cycles late, so the design sees no fixed phase.
   initial begin
      dig_in = 4'h0;
      pend_r = 1'b0;
   end

   always @(posedge core_clk) begin
      if (req_go) begin
         lvl_r  <= req_lvl;
         wait_r <= req_slow ? 2'd3 : 2'd0;
         pend_r <= 1'b1;
      end else if (pend_r && wait_r != 2'd0) begin
         wait_r <= wait_r - 2'd1;
      end else if (pend_r) begin
         dig_in <= lvl_r;
         pend_r <= 1'b0;
      end
   end
endmodule : field_contacts

// ---- sim/monitor_trigger_asserts.sv ----
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module monitor_trigger_asserts (
   input wire logic                       core_clk,
   input wire logic                       rst,
   input wire logic [3:0]                 dig_in,
   input wire logic                       reg_wr,
   input wire logic                       trig_valid,
   input wire trig_types_pkg::param_idx_t trig_param,
   input wire logic [1:0]                 trig_chan,
   input wire logic                       monitor_active,
   input wire logic                       digital_snapshot_event,
   input wire logic                       wave_save,
   input wire trig_types_pkg::param_idx_t wave_save_param,
   input wire trig_types_pkg::chan_mask_t wave_save_chans,
   input wire trig_types_pkg::harm_t      voltage_harmonic_limit,
   input wire trig_types_pkg::harm_t      current_harmonic_limit,
   input wire logic                       audible_warn
);
   timeunit 1ns;
   timeprecision 1ps;
   import trig_types_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_save_cause: assert property (wave_save |-> $past(trig_valid))
      else $error("wave save without trigger");
   a_save_param: assert property (wave_save |-> wave_save_param == $past(trig_param))
      else $error("wave save parameter wrong");
   a_chan_single: assert property (wave_save && wave_save_chans != 4'hF |->
      wave_save_chans == (4'h1 << $past(trig_chan)))
      else $error("single channel mask wrong");
   a_snap_pulse: assert property (digital_snapshot_event |=> !digital_snapshot_event)
      else $error("snapshot pulse too long");
   a_start_edge: assert property ($rose(monitor_active) |-> $past(dig_in[0], 4))
      else $error("start without input one high");
   a_stop_edge: assert property ($fell(monitor_active) |-> !$past(dig_in[1], 4))
      else $error("stop without input two low");
   a_warn_cause: assert property (audible_warn |-> $past(reg_wr))
      else $error("warning without write");
   a_harm_range: assert property (voltage_harmonic_limit inside {[2:50]} &&
      current_harmonic_limit inside {[2:50]})
      else $error("harmonic limit out of range");
endmodule : monitor_trigger_asserts

bind monitor_trigger_capture_control monitor_trigger_asserts u_chk (
   .core_clk(core_clk), .rst(rst), .dig_in(dig_in), .reg_wr(reg_wr), .trig_valid(trig_valid),
   .trig_param(trig_param), .trig_chan(trig_chan), .monitor_active(monitor_active),
   .digital_snapshot_event(digital_snapshot_event), .wave_save(wave_save),
   .wave_save_param(wave_save_param), .wave_save_chans(wave_save_chans),
   .voltage_harmonic_limit(voltage_harmonic_limit), .current_harmonic_limit(current_harmonic_limit),
   .audible_warn(audible_warn)
);

// ---- sim/testbench.sv ----
`include "monitor_trigger_defines.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import trig_types_pkg::*;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] dig_in, req_lvl = 4'h0;
   logic       req_go = 1'b0, req_slow = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
   logic       reg_wr = 1'b0, reg_rd = 1'b0, trig_valid = 1'b0;
   param_idx_t trig_param = 5'h00, wave_save_param;
   logic [1:0] trig_chan = 2'h0;
   logic       monitor_active, digital_snapshot_event, wave_save, audible_warn, irq;
   chan_mask_t wave_save_chans;
   harm_t      v_lim, i_lim;
   int         err_total = 0, tests_run = 0, snap_cnt = 0, warn_cnt = 0;

   always #20 core_clk = ~core_clk;

   field_contacts u_contacts (.core_clk(core_clk), .req_lvl(req_lvl), .req_go(req_go),
      .req_slow(req_slow), .dig_in(dig_in));

   monitor_trigger_capture_control DUT (
      .core_clk(core_clk), .rst(rst), .dig_in(dig_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_valid(trig_valid),
      .trig_param(trig_param), .trig_chan(trig_chan), .monitor_active(monitor_active),
      .digital_snapshot_event(digital_snapshot_event), .wave_save(wave_save),
      .wave_save_param(wave_save_param), .wave_save_chans(wave_save_chans),
      .voltage_harmonic_limit(v_lim), .current_harmonic_limit(i_lim),
      .audible_warn(audible_warn), .irq(irq));

   always @(posedge core_clk) begin
      if (digital_snapshot_event === 1'b1) snap_cnt++;
      if (audible_warn === 1'b1) warn_cnt++;
   end

   task automatic end_of_test();
      if (err_total == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(n, reg_rdata, exp);
   endtask : rd

   // Twelve idle cycles cover the synchroniser plus a slow contact.
   task automatic pin(input int i, input logic v, input logic slow);
      @(posedge core_clk);
      req_lvl[i] <= v;
      req_go     <= 1'b1;
      req_slow   <= slow;
      @(posedge core_clk);
      req_go <= 1'b0;
      repeat (12) @(posedge core_clk);
      #1;
   endtask : pin

   task automatic trig(input param_idx_t p, input logic [1:0] c, input logic s, input chan_mask_t m);
      @(posedge core_clk);
      trig_valid <= 1'b1;
      trig_param <= p;
      trig_chan  <= c;
      @(posedge core_clk);
      trig_valid <= 1'b0;
      #1;
      chk("wave_save", wave_save, s);
      if (s) chk("wave_chans", wave_save_chans, m);
      if (s) chk("wave_param", wave_save_param, p);
   endtask : trig

   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rd(`OFS_WAVE_EN, 32'h0000_0000, "wave_rst");
      rd(`OFS_ALL_EN, 32'h0000_0000, "all_rst");
      rd(8'h3C, 32'h0000_0000, "unmapped");
      pin(0, 1'b1, 1'b0);
      chk("mon_unpaired", monitor_active, 1'b0);
      pin(0, 1'b0, 1'b0);
      wr(`OFS_CTRL, 32'h0000_0007);
      pin(0, 1'b1, 1'b1);
      chk("mon_start", monitor_active, 1'b1);
      pin(2, 1'b1, 1'b0);
      chk("snap3", snap_cnt, 32'h0000_0001);
      chk("mon_hold", monitor_active, 1'b1);
      pin(1, 1'b1, 1'b0);
      chk("mon_rise2", monitor_active, 1'b1);
      pin(1, 1'b0, 1'b1);
      chk("mon_stop", monitor_active, 1'b0);
      pin(3, 1'b1, 1'b0);
      chk("snap4", snap_cnt, 32'h0000_0002);
      wr(`OFS_CTRL, 32'h0000_0003);
      pin(3, 1'b0, 1'b0);
      pin(3, 1'b1, 1'b0);
      chk("snap4_off", snap_cnt, 32'h0000_0002);
      wr(`OFS_CAPT_EDIT, 32'h0000_0305);
      wr(`OFS_CAPT_EDIT, 32'h0000_0106);
      wr(`OFS_CAPT_EDIT, 32'h0000_0207);
      wr(`OFS_CAPT_EDIT, 32'h0000_0116);
      trig(5'd5, 2'd2, 1'b0, 4'h0);
      chk("warn_capt", warn_cnt, 32'h0000_0002);
      rd(`OFS_STATUS, 32'h0000_0002, "status_dirty");
      wr(`OFS_EDIT_EXIT, 32'h0000_0000);
      rd(`OFS_WAVE_EN, 32'h0000_0060, "wave_en");
      rd(`OFS_ALL_EN, 32'h0000_0020, "all_en");
      trig(5'd5, 2'd2, 1'b1, 4'hF);
      trig(5'd6, 2'd2, 1'b1, 4'h4);
      trig(5'd6, 2'd3, 1'b1, 4'h8);
      trig(5'd7, 2'd1, 1'b0, 4'h0);
      trig(5'd22, 2'd0, 1'b0, 4'h0);
      wr(`OFS_HARM, 32'h0000_0832);
      wr(`OFS_HARM, 32'h0000_0233);
      wr(`OFS_HARM, 32'h0000_0102);
      wr(`OFS_EDIT_EXIT, 32'h0000_0000);
      rd(`OFS_HARM, 32'h0000_0832, "harm60");
      chk("harm_v", v_lim, 32'h0000_0032);
      wr(`OFS_CTRL, 32'h0000_0008);
      wr(`OFS_HARM, 32'h0000_0209);
      wr(`OFS_HARM, 32'h0000_0802);
      wr(`OFS_EDIT_EXIT, 32'h0000_0000);
      rd(`OFS_HARM, 32'h0000_0802, "harm400");
      chk("harm_i", i_lim, 32'h0000_0008);
      wr(`OFS_NAME_LEN, 32'h0000_0000);
      for (int k = 0; k < 30; k++) wr(`OFS_NAME_CHAR, 32'h0000_0041 + k);
      rd(`OFS_NAME_LEN, 32'h0000_001D, "name_len");
      rd(8'hF0, 32'h0000_005D, "name_last");
      chk("warn_all", warn_cnt, 32'h0000_0006);
      rd(`OFS_INT_STS, 32'h0000_001F, "int_sts");
      wr(`OFS_INT_MASK, 32'h0000_0004);
      chk("irq_on", irq, 1'b1);
      wr(`OFS_INT_STS, 32'h0000_0004);
      chk("irq_off", irq, 1'b0);
      rd(`OFS_INT_STS, 32'h0000_001B, "int_w1c");
      end_of_test();
   end

   initial begin
      #160000;
      err_total++;
      end_of_test();
   end
endmodule : testbench
